// ==== verilog/cxe_map.vh ====
`ifndef CXE_MAP_VH
`define CXE_MAP_VH

// Major opcode groups, taken from bits 7:4 of the first byte.
`define CXE_MJ_LOADACC    4'h0
`define CXE_MJ_RELBR      4'h1
`define CXE_MJ_ONEB       4'h2
`define CXE_MJ_RETGRP     4'h3
`define CXE_MJ_PAIRSTK    4'h4
`define CXE_MJ_CMPREG     4'h5
`define CXE_MJ_TWOB       4'h6
`define CXE_MJ_LOADPAIR   4'h7
`define CXE_MJ_PAGEJUMP   4'h8
`define CXE_MJ_SHORTENTRY 4'h9
`define CXE_MJ_LONGJUMP   4'ha
`define CXE_MJ_LONGCALL   4'hb

// One-byte group with bit 3 set, selected by bits 2:0.
`define CXE_S1_CMPACCMEM  3'h0
`define CXE_S1_SWAPUP     3'h1
`define CXE_S1_SWAPDN     3'h2
`define CXE_S1_FETCHUP    3'h3
`define CXE_S1_FETCHDN    3'h4
`define CXE_S1_ROTATE     3'h5
`define CXE_S1_PROGBYTEP  3'h6
`define CXE_S1_PROGBYTEW  3'h7

// Return and nibble-logic group, selected by bits 3:0.
`define CXE_SR_RETURN     4'h0
`define CXE_SR_INTEXIT    4'h1
`define CXE_SR_SKIPEXIT   4'h2
`define CXE_SR_ANDMEM     4'h3
`define CXE_SR_ORMEM      4'h4
`define CXE_SR_XORMEM     4'h5

// Two-byte group, selected by bits 3:0.
`define CXE_S2_CMPMEMIM   4'h0
`define CXE_S2_CMPWIDEMEM 4'h1
`define CXE_S2_CMPWIDEPR  4'h2
`define CXE_S2_CMPACCREG  4'h3
`define CXE_S2_BRPTR      4'h4
`define CXE_S2_BRWIDE     4'h5
`define CXE_S2_SWAPWDIR   4'h6
`define CXE_S2_ANDPAIR    4'h7
`define CXE_S2_ORPAIR     4'h8
`define CXE_S2_XORPAIR    4'h9
`define CXE_S2_PUSHBANK   4'ha
`define CXE_S2_POPBANK    4'hb

// Register and pair indices.
`define CXE_R_ACC         3'd0
`define CXE_R_EXT         3'd1
`define CXE_R_PLO         3'd2
`define CXE_P_WIDE        2'd0
`define CXE_P_DPTR        2'd1
`define CXE_P_BPTR        2'd2

// Sizes in bytes and costs in machine cycles.
`define CXE_LEN1          2'd1
`define CXE_LEN2          2'd2
`define CXE_LEN3          2'd3
`define CXE_CYC1          3'd1
`define CXE_CYC2          3'd2
`define CXE_CYC3          3'd3
`define CXE_CYC4          3'd4
`define CXE_SKIP_SHORT    3'd1
`define CXE_SKIP_LONG     3'd2

// Reset values and stack address width.
`define CXE_PC_RST        14'h0000
`define CXE_BANK_RST      4'h0
`define CXE_STK_AW        4

`endif

// ==== verilog/cxe_op_timing.v ====
`timescale 1ns/1ps
`include "cxe_map.vh"

module cxe_op_timing (
	input  wire [7:0] opByte,
	output reg  [1:0] opLen,
	output reg  [2:0] opCyc
);

	always @* begin
		opLen = `CXE_LEN1;
		opCyc = `CXE_CYC1;
		case (opByte[7:4])
			`CXE_MJ_RELBR: begin
				opCyc = `CXE_CYC2;
			end
			`CXE_MJ_ONEB: begin
				if (opByte[3]) begin
					case (opByte[2:0])
						`CXE_S1_SWAPUP, `CXE_S1_SWAPDN,
						`CXE_S1_FETCHUP, `CXE_S1_FETCHDN: begin
							opCyc = `CXE_CYC2;
						end
						`CXE_S1_PROGBYTEP, `CXE_S1_PROGBYTEW: begin
							opCyc = `CXE_CYC3;
						end
						default: begin
							opCyc = `CXE_CYC1;
						end
					endcase
				end
			end
			`CXE_MJ_RETGRP: begin
				if (opByte[3:0] == `CXE_SR_RETURN || opByte[3:0] == `CXE_SR_INTEXIT ||
				    opByte[3:0] == `CXE_SR_SKIPEXIT) begin
					opCyc = `CXE_CYC3;
				end
			end
			`CXE_MJ_CMPREG, `CXE_MJ_LOADPAIR, `CXE_MJ_PAGEJUMP: begin
				opLen = `CXE_LEN2;
				opCyc = `CXE_CYC2;
			end
			`CXE_MJ_TWOB: begin
				opLen = `CXE_LEN2;
				if (opByte[3:0] == `CXE_S2_BRPTR || opByte[3:0] == `CXE_S2_BRWIDE) begin
					opCyc = `CXE_CYC3;
				end else begin
					opCyc = `CXE_CYC2;
				end
			end
			`CXE_MJ_SHORTENTRY: begin
				opLen = `CXE_LEN2;
				opCyc = `CXE_CYC3;
			end
			`CXE_MJ_LONGJUMP: begin
				opLen = `CXE_LEN3;
				opCyc = `CXE_CYC3;
			end
			`CXE_MJ_LONGCALL: begin
				opLen = `CXE_LEN3;
				opCyc = `CXE_CYC4;
			end
			default: begin
				opLen = `CXE_LEN1;
				opCyc = `CXE_CYC1;
			end
		endcase
	end

endmodule

// ==== verilog/cxe_stack.v ====
`timescale 1ns/1ps
`include "cxe_map.vh"

module cxe_stack (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        push,
	input  wire        pop,
	input  wire [15:0] wrData,
	output wire [15:0] topData
);

	reg  [15:0]            entries [0:(1 << `CXE_STK_AW) - 1];
	reg  [`CXE_STK_AW-1:0] sp_q;
	wire [`CXE_STK_AW-1:0] spTop;

	// The pointer wraps, so overflow silently overwrites the oldest entry.
	assign spTop   = sp_q - {{(`CXE_STK_AW-1){1'b0}}, 1'b1};
	assign topData = entries[spTop];

	always @(posedge clock) begin
		if (push) begin
			entries[sp_q] <= wrData;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= {`CXE_STK_AW{1'b0}};
		end else if (push) begin
			sp_q <= sp_q + {{(`CXE_STK_AW-1){1'b0}}, 1'b1};
		end else if (pop) begin
			sp_q <= spTop;
		end
	end

endmodule

// ==== verilog/cxe_exec_core.v ====
`timescale 1ns/1ps
`include "cxe_map.vh"

module cxe_exec_core (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [7:0]  progData,
	input  wire [7:0]  dataRdData,
	output reg  [13:0] progAddr,
	output reg  [7:0]  dataAddr,
	output reg         dataWide,
	output reg         dataWrEn,
	output reg  [7:0]  dataWrData,
	output wire [13:0] pcOut,
	output wire [7:0]  wideAccOut,
	output wire        carryOut,
	output wire        skipActive,
	output wire        instrDone,
	output wire [3:0]  memBankSel,
	output wire [3:0]  regBankSel
);

	reg  [13:0] pc_q;
	reg  [1:0]  cyc_q;
	reg  [7:0]  op_q;
	reg  [7:0]  byte1_q;
	reg  [7:0]  byte2_q;
	reg         skip_q;
	reg         carry_q;
	reg  [3:0]  memBank_q;
	reg  [3:0]  regBank_q;
	reg  [3:0]  regs_q [0:7];

	wire [7:0]  curOp;
	wire [7:0]  curB1;
	wire [7:0]  curB2;
	wire [3:0]  major;
	wire [3:0]  minor;
	wire [1:0]  opLen;
	wire [2:0]  opCyc;
	reg  [2:0]  needCyc;
	wire        lastCyc;
	wire        exec;
	wire [13:0] pcSeq;
	wire [7:0]  pairVal [0:3];
	wire [7:0]  wideAcc;
	wire [7:0]  dataPtr;
	wire [7:0]  bytePtr;
	wire [3:0]  acc;
	wire [3:0]  ptrLow;
	wire [4:0]  ptrLowUp;
	wire [3:0]  ptrLowDn;
	wire [3:0]  regOp;
	wire [3:0]  regB1;
	wire [7:0]  pairB1;
	wire [3:0]  memNib;
	wire [15:0] stkTop;
	reg         stkPush;
	reg         stkPop;
	reg  [15:0] stkWrData;

	// The opcode byte is live on the bus in cycle 0 and held afterwards.
	assign curOp   = (cyc_q == 2'd0) ? progData : op_q;
	assign curB1   = (cyc_q == 2'd1) ? progData : byte1_q;
	assign curB2   = (cyc_q == 2'd2) ? progData : byte2_q;
	assign major   = curOp[7:4];
	assign minor   = curOp[3:0];

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gPair
			assign pairVal[g] = {regs_q[2*g+1], regs_q[2*g]};
		end
	endgenerate

	assign wideAcc  = pairVal[`CXE_P_WIDE];
	assign dataPtr  = pairVal[`CXE_P_DPTR];
	assign bytePtr  = pairVal[`CXE_P_BPTR];
	assign acc      = regs_q[`CXE_R_ACC];
	assign ptrLow   = regs_q[`CXE_R_PLO];
	assign ptrLowUp = {1'b0, ptrLow} + 5'd1;
	assign ptrLowDn = ptrLow - 4'd1;
	assign regOp    = regs_q[curOp[2:0]];
	assign regB1    = regs_q[curB1[2:0]];
	assign pairB1   = pairVal[curB1[2:1]];
	assign memNib   = dataRdData[3:0];

	cxe_op_timing uTiming (
		.opByte (curOp),
		.opLen  (opLen),
		.opCyc  (opCyc)
	);

	cxe_stack uStack (
		.clock   (clock),
		.rst_n   (rst_n),
		.push    (stkPush),
		.pop     (stkPop),
		.wrData  (stkWrData),
		.topData (stkTop)
	);

	always @* begin
		if (skip_q) begin
			needCyc = (opLen == `CXE_LEN3) ? `CXE_SKIP_LONG : `CXE_SKIP_SHORT;
		end else begin
			needCyc = opCyc;
		end
	end

	assign lastCyc = ({1'b0, cyc_q} == (needCyc - 3'd1));
	assign exec    = !skip_q && lastCyc;
	assign pcSeq   = pc_q + {12'h000, opLen};

	assign pcOut      = pc_q;
	assign wideAccOut = wideAcc;
	assign carryOut   = carry_q;
	assign skipActive = skip_q;
	assign instrDone  = lastCyc;
	assign memBankSel = memBank_q;
	assign regBankSel = regBank_q;

	// Memory and stack strobes; all writes land on the executing edge.
	always @* begin
		progAddr   = pc_q + {12'h000, cyc_q};
		dataAddr   = dataPtr;
		dataWide   = 1'b0;
		dataWrEn   = 1'b0;
		dataWrData = 8'h00;
		stkPush    = 1'b0;
		stkPop     = 1'b0;
		stkWrData  = 16'h0000;
		if (!skip_q) begin
			case (major)
				`CXE_MJ_ONEB: begin
					if (curOp[3]) begin
						case (curOp[2:0])
							`CXE_S1_SWAPUP, `CXE_S1_SWAPDN: begin
								dataWrEn   = exec;
								dataWrData = {4'h0, acc};
							end
							`CXE_S1_PROGBYTEP, `CXE_S1_PROGBYTEW: begin
								if (cyc_q == 2'd2) begin
									progAddr = {pc_q[13:8], curOp[0] ? wideAcc : bytePtr};
								end
							end
							default: begin
								dataWrEn = 1'b0;
							end
						endcase
					end
				end
				`CXE_MJ_RETGRP: begin
					if (minor == `CXE_SR_RETURN || minor == `CXE_SR_INTEXIT ||
					    minor == `CXE_SR_SKIPEXIT) begin
						stkPop = exec;
					end
				end
				`CXE_MJ_PAIRSTK: begin
					stkPush   = exec && !curOp[3];
					stkPop    = exec && curOp[3];
					stkWrData = {8'h00, pairVal[curOp[2:1]]};
				end
				`CXE_MJ_TWOB: begin
					case (minor)
						`CXE_S2_CMPWIDEMEM: begin
							dataWide = 1'b1;
						end
						`CXE_S2_SWAPWDIR: begin
							dataAddr   = curB1;
							dataWide   = 1'b1;
							dataWrEn   = exec;
							dataWrData = wideAcc;
						end
						`CXE_S2_PUSHBANK: begin
							stkPush   = exec;
							stkWrData = {8'h00, memBank_q, regBank_q};
						end
						`CXE_S2_POPBANK: begin
							stkPop = exec;
						end
						default: begin
							dataWide = 1'b0;
						end
					endcase
				end
				`CXE_MJ_SHORTENTRY, `CXE_MJ_LONGCALL: begin
					stkPush   = exec;
					stkWrData = {carry_q, 1'b0, pcSeq};
				end
				default: begin
					dataWrEn = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clock or negedge rst_n) begin : pSeq
		integer i;
		if (!rst_n) begin
			pc_q      <= `CXE_PC_RST;
			cyc_q     <= 2'd0;
			op_q      <= 8'h00;
			byte1_q   <= 8'h00;
			byte2_q   <= 8'h00;
			skip_q    <= 1'b0;
			carry_q   <= 1'b0;
			memBank_q <= `CXE_BANK_RST;
			regBank_q <= `CXE_BANK_RST;
			for (i = 0; i < 8; i = i + 1) begin
				regs_q[i] <= 4'h0;
			end
		end else begin
			if (cyc_q == 2'd0) begin
				op_q <= progData;
			end
			if (cyc_q == 2'd1) begin
				byte1_q <= progData;
			end
			if (cyc_q == 2'd2) begin
				byte2_q <= progData;
			end
			if (lastCyc) begin
				cyc_q <= 2'd0;
				pc_q  <= pcSeq;
			end else begin
				cyc_q <= cyc_q + 2'd1;
			end
			if (skip_q && lastCyc) begin
				skip_q <= 1'b0;
			end
			if (exec) begin
				case (major)
					`CXE_MJ_LOADACC: begin
						regs_q[`CXE_R_ACC] <= minor;
					end
					`CXE_MJ_RELBR: begin
						pc_q <= pc_q + 14'd1 + {{10{minor[3]}}, minor};
					end
					`CXE_MJ_ONEB: begin
						if (!curOp[3]) begin
							regs_q[`CXE_R_ACC] <= regOp;
							regs_q[curOp[2:0]] <= acc;
						end else begin
							case (curOp[2:0])
								`CXE_S1_CMPACCMEM: begin
									skip_q <= (acc == memNib);
								end
								`CXE_S1_SWAPUP, `CXE_S1_FETCHUP: begin
									regs_q[`CXE_R_ACC] <= memNib;
									regs_q[`CXE_R_PLO] <= ptrLowUp[3:0];
									skip_q             <= ptrLowUp[4];
								end
								`CXE_S1_SWAPDN, `CXE_S1_FETCHDN: begin
									regs_q[`CXE_R_ACC] <= memNib;
									regs_q[`CXE_R_PLO] <= ptrLowDn;
									skip_q             <= (ptrLow == 4'h0);
								end
								`CXE_S1_ROTATE: begin
									regs_q[`CXE_R_ACC] <= {carry_q, acc[3:1]};
									carry_q            <= acc[0];
								end
								default: begin
									regs_q[`CXE_R_ACC] <= progData[3:0];
									regs_q[`CXE_R_EXT] <= progData[7:4];
								end
							endcase
						end
					end
					`CXE_MJ_RETGRP: begin
						case (minor)
							`CXE_SR_RETURN: begin
								pc_q <= stkTop[13:0];
							end
							`CXE_SR_INTEXIT: begin
								pc_q    <= stkTop[13:0];
								carry_q <= stkTop[15];
							end
							`CXE_SR_SKIPEXIT: begin
								pc_q   <= stkTop[13:0];
								skip_q <= 1'b1;
							end
							`CXE_SR_ANDMEM: begin
								regs_q[`CXE_R_ACC] <= acc & memNib;
							end
							`CXE_SR_ORMEM: begin
								regs_q[`CXE_R_ACC] <= acc | memNib;
							end
							`CXE_SR_XORMEM: begin
								regs_q[`CXE_R_ACC] <= acc ^ memNib;
							end
							default: begin
								skip_q <= 1'b0;
							end
						endcase
					end
					`CXE_MJ_PAIRSTK: begin
						if (curOp[3]) begin
							regs_q[{curOp[2:1], 1'b0}] <= stkTop[3:0];
							regs_q[{curOp[2:1], 1'b1}] <= stkTop[7:4];
						end
					end
					`CXE_MJ_CMPREG: begin
						skip_q <= (regOp == curB1[3:0]);
					end
					`CXE_MJ_TWOB: begin
						case (minor)
							`CXE_S2_CMPMEMIM: begin
								skip_q <= (memNib == curB1[3:0]);
							end
							`CXE_S2_CMPWIDEMEM: begin
								skip_q <= (wideAcc == dataRdData);
							end
							`CXE_S2_CMPWIDEPR: begin
								skip_q <= (wideAcc == pairB1);
							end
							`CXE_S2_CMPACCREG: begin
								skip_q <= (acc == regB1);
							end
							`CXE_S2_BRPTR: begin
								pc_q <= pc_q + 14'd2 + {6'h00, bytePtr};
							end
							`CXE_S2_BRWIDE: begin
								pc_q <= pc_q + 14'd2 + {6'h00, wideAcc};
							end
							`CXE_S2_SWAPWDIR: begin
								regs_q[`CXE_R_ACC] <= dataRdData[3:0];
								regs_q[`CXE_R_EXT] <= dataRdData[7:4];
							end
							`CXE_S2_ANDPAIR: begin
								regs_q[`CXE_R_ACC] <= acc & pairB1[3:0];
								regs_q[`CXE_R_EXT] <= regs_q[`CXE_R_EXT] & pairB1[7:4];
							end
							`CXE_S2_ORPAIR: begin
								regs_q[`CXE_R_ACC] <= acc | pairB1[3:0];
								regs_q[`CXE_R_EXT] <= regs_q[`CXE_R_EXT] | pairB1[7:4];
							end
							`CXE_S2_XORPAIR: begin
								regs_q[`CXE_R_ACC] <= acc ^ pairB1[3:0];
								regs_q[`CXE_R_EXT] <= regs_q[`CXE_R_EXT] ^ pairB1[7:4];
							end
							`CXE_S2_POPBANK: begin
								memBank_q <= stkTop[7:4];
								regBank_q <= stkTop[3:0];
							end
							default: begin
								skip_q <= 1'b0;
							end
						endcase
					end
					`CXE_MJ_LOADPAIR: begin
						regs_q[{curOp[2:1], 1'b0}] <= curB1[3:0];
						regs_q[{curOp[2:1], 1'b1}] <= curB1[7:4];
					end
					`CXE_MJ_PAGEJUMP: begin
						pc_q <= {pc_q[13:12], minor, curB1};
					end
					`CXE_MJ_SHORTENTRY: begin
						pc_q <= {pc_q[13:11], curOp[2:0], curB1};
					end
					`CXE_MJ_LONGJUMP, `CXE_MJ_LONGCALL: begin
						pc_q <= {curB1[5:0], curB2};
					end
					default: begin
						skip_q <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// ==== testbench/cxe_exec_props.sv ====
`timescale 1ns/1ps
module cxe_exec_props (
	input wire        clock,
	input wire        rst_n,
	input wire [7:0]  progData,
	input wire [7:0]  dataRdData,
	input wire [13:0] progAddr,
	input wire        dataWrEn,
	input wire [13:0] pcOut,
	input wire [7:0]  wideAccOut,
	input wire        carryOut,
	input wire        skipActive,
	input wire        instrDone
);
	reg       start_q;
	reg [7:0] op_q;
	reg [7:0] acc_q;
	reg [7:0] mem_q;
	reg       carry_q;

	// Flags the first cycle of each instruction and keeps copies from the cycle before.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 1'b1;
			op_q    <= 8'h00;
			acc_q   <= 8'h00;
			mem_q   <= 8'h00;
			carry_q <= 1'b0;
		end else begin
			start_q <= instrDone;
			op_q    <= progData;
			acc_q   <= wideAccOut;
			mem_q   <= dataRdData;
			carry_q <= carryOut;
		end
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_exec;
		start_q && !skipActive;
	endsequence
	sequence s_twoCyc;
		!instrDone ##1 instrDone;
	endsequence
	sequence s_threeCyc;
		!instrDone [*2] ##1 instrDone;
	endsequence
	sequence s_fourCyc;
		!instrDone [*3] ##1 instrDone;
	endsequence

	property p_longJump;
		s_exec ##0 progData[7:4] == 4'ha |-> s_threeCyc;
	endproperty
	property p_longCall;
		s_exec ##0 progData[7:4] == 4'hb |-> s_fourCyc;
	endproperty
	property p_pageJump;
		s_exec ##0 progData[7:4] == 4'h8 |-> s_twoCyc;
	endproperty
	property p_loadImm;
		s_exec ##0 progData[7:4] == 4'h0 |-> instrDone ##1 wideAccOut[3:0] == op_q[3:0];
	endproperty
	property p_rotate;
		s_exec ##0 progData == 8'h2d |-> instrDone ##1
			(carryOut == acc_q[0] && wideAccOut == {acc_q[7:4], carry_q, acc_q[3:1]});
	endproperty
	property p_cmpMem;
		s_exec ##0 progData == 8'h28 |-> instrDone ##1 skipActive == (mem_q[3:0] == acc_q[3:0]);
	endproperty
	property p_skipShort;
		start_q && skipActive && progData[7:5] != 3'b101 |-> instrDone;
	endproperty
	property p_skipLong;
		start_q && skipActive && progData[7:5] == 3'b101 |-> s_twoCyc;
	endproperty
	property p_skipQuiet;
		skipActive |-> !dataWrEn;
	endproperty
	property p_skipKeep;
		skipActive && instrDone |=> $stable(wideAccOut) && $stable(carryOut);
	endproperty
	property p_pcHold;
		!instrDone |=> $stable(pcOut);
	endproperty
	property p_fetchStart;
		instrDone |=> progAddr == pcOut;
	endproperty

	a_longJump: assert property (p_longJump) else $error("long jump cycle count wrong");
	a_longCall: assert property (p_longCall) else $error("long call cycle count wrong");
	a_pageJump: assert property (p_pageJump) else $error("page jump cycle count wrong");
	a_loadImm: assert property (p_loadImm) else $error("immediate load wrong");
	a_rotate: assert property (p_rotate) else $error("rotate through carry wrong");
	a_cmpMem: assert property (p_cmpMem) else $error("compare skip decision wrong");
	a_skipShort: assert property (p_skipShort) else $error("short skip not one cycle");
	a_skipLong: assert property (p_skipLong) else $error("long skip not two cycles");
	a_skipQuiet: assert property (p_skipQuiet) else $error("write during skip");
	a_skipKeep: assert property (p_skipKeep) else $error("state changed by skip");
	a_pcHold: assert property (p_pcHold) else $error("pc moved mid instruction");
	a_fetchStart: assert property (p_fetchStart) else $error("fetch not at pc");
endmodule

// ==== testbench/cxe_mem_model.sv ====
`timescale 1ns/1ps
module cxe_mem_model (
	input  wire        clock,
	input  wire [13:0] progAddr,
	output wire [7:0]  progData,
	input  wire [7:0]  dataAddr,
	input  wire        dataWide,
	input  wire        dataWrEn,
	input  wire [7:0]  dataWrData,
	output wire [7:0]  dataRdData
);
	reg [7:0] progMem [0:16383];
	reg [7:0] dataMem [0:255];

	assign progData   = progMem[progAddr];
	assign dataRdData = dataMem[dataAddr];

	// A nibble write leaves the upper half of the location untouched.
	always @(posedge clock) begin
		if (dataWrEn) begin
			if (dataWide)
				dataMem[dataAddr] <= dataWrData;
			else
				dataMem[dataAddr] <= {dataMem[dataAddr][7:4], dataWrData[3:0]};
		end
	end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	reg         clock;
	reg         rst_n;
	wire [7:0]  progData;
	wire [7:0]  dataRdData;
	wire [13:0] progAddr;
	wire [7:0]  dataAddr;
	wire        dataWide;
	wire        dataWrEn;
	wire [7:0]  dataWrData;
	wire [13:0] pcOut;
	wire [7:0]  wideAccOut;
	wire        carryOut;
	wire        skipActive;
	wire        instrDone;
	wire [3:0]  memBankSel;
	wire [3:0]  regBankSel;
	integer     miscompares;
	integer     tests_run;
	integer     i;

	cxe_exec_core u_dut (.clock(clock), .rst_n(rst_n), .progData(progData),
		.dataRdData(dataRdData), .progAddr(progAddr), .dataAddr(dataAddr),
		.dataWide(dataWide), .dataWrEn(dataWrEn), .dataWrData(dataWrData),
		.pcOut(pcOut), .wideAccOut(wideAccOut), .carryOut(carryOut),
		.skipActive(skipActive), .instrDone(instrDone), .memBankSel(memBankSel),
		.regBankSel(regBankSel));
	cxe_mem_model u_mem (.clock(clock), .progAddr(progAddr), .progData(progData),
		.dataAddr(dataAddr), .dataWide(dataWide), .dataWrEn(dataWrEn),
		.dataWrData(dataWrData), .dataRdData(dataRdData));

	always #25 clock = ~clock;

	task chk(input [15:0] got, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// Reset goes low before the clear, so no write of a running instruction lands afterwards.
	task boot;
		begin
			@(posedge clock);
			rst_n <= 1'b0;
			#1;
			for (i = 0; i < 16384; i = i + 1)
				u_mem.progMem[i] = 8'h00;
			for (i = 0; i < 256; i = i + 1)
				u_mem.dataMem[i] = 8'h00;
			repeat (5) @(posedge clock);
			#1;
		end
	endtask

	task go;
		begin
			@(posedge clock);
			rst_n <= 1'b1;
		end
	endtask

	task step(input integer n);
		begin
			repeat (n) @(posedge clock);
			#1;
		end
	endtask

	task put1(input [13:0] a, input [7:0] b);
		u_mem.progMem[a] = b;
	endtask

	task put2(input [13:0] a, input [15:0] b);
		begin
			put1(a, b[15:8]);
			put1(a + 14'h1, b[7:0]);
		end
	endtask

	task put3(input [13:0] a, input [23:0] b);
		begin
			put1(a, b[23:16]);
			put2(a + 14'h1, b[15:0]);
		end
	endtask

	task test_jump;
		begin
			boot;
			chk({2'h0, pcOut}, 16'h0000);
			chk({carryOut, skipActive, 6'h00, wideAccOut}, 16'h0000);
			chk({8'h00, memBankSel, regBankSel}, 16'h0000);
			put1(14'h0, 8'h05);
			put3(14'h1, 24'ha12345);
			go;
			step(3);
			chk({2'h0, pcOut}, 16'h0001);
			step(1);
			chk({2'h0, pcOut}, 16'h2345);
			chk({8'h00, wideAccOut}, 16'h0005);
			$display("test_jump done");
		end
	endtask

	task test_call;
		begin
			boot;
			put3(14'h0, 24'hb00100);
			put3(14'h3, 24'ha00020);
			put1(14'h6, 8'h07);
			put1(14'h100, 8'h32);
			go;
			step(4);
			chk({2'h0, pcOut}, 16'h0100);
			step(3);
			chk({1'b0, skipActive, pcOut}, 16'h4003);
			step(1);
			chk({2'h0, pcOut}, 16'h0003);
			step(1);
			chk({2'h0, pcOut}, 16'h0006);
			step(1);
			chk({2'h0, pcOut}, 16'h0007);
			chk({8'h00, wideAccOut}, 16'h0007);
			$display("test_call done");
		end
	endtask

	task test_swap;
		begin
			boot;
			put2(14'h0, 16'h720f);
			put1(14'h2, 8'h05);
			put1(14'h3, 8'h29);
			put1(14'h4, 8'h0e);
			u_mem.dataMem[15] = 8'h03;
			go;
			step(5);
			chk({1'b0, skipActive, pcOut}, 16'h4004);
			chk({8'h00, wideAccOut}, 16'h0003);
			chk({8'h00, u_mem.dataMem[15]}, 16'h0005);
			step(1);
			chk({2'h0, pcOut}, 16'h0005);
			chk({8'h00, wideAccOut}, 16'h0003);
			$display("test_swap done");
		end
	endtask

	task test_rotate;
		begin
			boot;
			put1(14'h0, 8'h09);
			put1(14'h1, 8'h2d);
			put1(14'h2, 8'h2d);
			go;
			step(2);
			chk({7'h00, carryOut, wideAccOut}, 16'h0104);
			step(1);
			chk({7'h00, carryOut, wideAccOut}, 16'h000a);
			$display("test_rotate done");
		end
	endtask

	task test_compare;
		begin
			boot;
			put1(14'h0, 8'h03);
			put2(14'h1, 16'h5003);
			put1(14'h3, 8'h07);
			put2(14'h4, 16'h5004);
			put1(14'h6, 8'h08);
			put1(14'h7, 8'h28);
			u_mem.dataMem[0] = 8'h08;
			go;
			step(3);
			chk({1'b0, skipActive, pcOut}, 16'h4003);
			step(1);
			chk({8'h00, wideAccOut}, 16'h0003);
			step(2);
			chk({1'b0, skipActive, pcOut}, 16'h0006);
			step(2);
			chk({1'b0, skipActive, pcOut}, 16'h4008);
			$display("test_compare done");
		end
	endtask

	task test_rel;
		begin
			boot;
			put1(14'h0, 8'h12);
			put2(14'h3, 16'h8123);
			go;
			step(1);
			chk({2'h0, pcOut}, 16'h0000);
			step(1);
			chk({2'h0, pcOut}, 16'h0003);
			step(1);
			chk({2'h0, pcOut}, 16'h0003);
			step(1);
			chk({2'h0, pcOut}, 16'h0123);
			$display("test_rel done");
		end
	endtask

	task test_sub;
		begin
			boot;
			put2(14'h0, 16'h745a);
			put1(14'h2, 8'h44);
			put2(14'h3, 16'h6b00);
			put1(14'h5, 8'h2e);
			put2(14'h6, 16'h9100);
			put2(14'h8, 16'h6410);
			put1(14'h5a, 8'hc3);
			put2(14'h100, 16'h2530);
			go;
			step(5);
			chk({8'h00, memBankSel, regBankSel}, 16'h005a);
			step(3);
			chk({8'h00, wideAccOut}, 16'h00c3);
			step(3);
			chk({2'h0, pcOut}, 16'h0100);
			step(1);
			chk({8'h00, wideAccOut}, 16'h00c5);
			step(3);
			chk({2'h0, pcOut}, 16'h0008);
			step(3);
			chk({2'h0, pcOut}, 16'h0044);
			$display("test_sub done");
		end
	endtask

	task test_data;
		begin
			boot;
			put2(14'h0, 16'h012d);
			put3(14'h2, 24'hb00040);
			put2(14'h5, 16'h6620);
			put2(14'h7, 16'h2c0e);
			put2(14'h9, 16'h6702);
			put2(14'hb, 16'h6100);
			put2(14'h40, 16'h2d31);
			u_mem.dataMem[0] = 8'h07;
			u_mem.dataMem[15] = 8'h07;
			u_mem.dataMem[32] = 8'h96;
			go;
			step(7);
			chk({7'h00, carryOut, wideAccOut}, 16'h0008);
			step(3);
			chk({carryOut, 1'b0, pcOut}, 16'h8005);
			step(2);
			chk({8'h00, wideAccOut}, 16'h0096);
			chk({8'h00, u_mem.dataMem[32]}, 16'h0008);
			step(2);
			chk({1'b0, skipActive, pcOut}, 16'h4008);
			chk({8'h00, wideAccOut}, 16'h0097);
			step(1);
			chk({8'h00, wideAccOut}, 16'h0097);
			step(2);
			chk({8'h00, wideAccOut}, 16'h0007);
			step(2);
			chk({1'b0, skipActive, pcOut}, 16'h400d);
			$display("test_data done");
		end
	endtask

	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, miscompares);
			if (miscompares == 0 && tests_run > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		miscompares = 0;
		tests_run = 0;
		test_jump;
		test_call;
		test_swap;
		test_rotate;
		test_compare;
		test_rel;
		test_sub;
		test_data;
		end_sim;
	end

	initial begin
		#100000;
		miscompares = miscompares + 1;
		end_sim;
	end
endmodule

bind cxe_exec_core cxe_exec_props u_props (.clock(clock), .rst_n(rst_n),
	.progData(progData), .dataRdData(dataRdData), .progAddr(progAddr),
	.dataWrEn(dataWrEn), .pcOut(pcOut), .wideAccOut(wideAccOut),
	.carryOut(carryOut), .skipActive(skipActive), .instrDone(instrDone));
